// ### core/ifepr_prio_bank.sv
// bank of priority control words: masked writes, registered read, per-source level fields
`timescale 1ns/100ps
`include "ifepr_params.svh"

module ifepr_prio_bank (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // write port
  input wire logic i_wr,
  input wire logic [2:0] i_widx,
  input wire logic [31:0] i_wdata,
  input wire logic [31:0] i_wmask,
  // read port
  input wire logic [2:0] i_ridx,
  output logic [31:0] o_rdata,
  // decoded fields, three and two bits per source
  output logic [95:0] o_level,
  output logic [63:0] o_sublevel
);

  logic [31:0] word_q [0:`IFEPR_NUM_PCW-1];
  logic [31:0] rdata_q;
  logic [31:0] wr_keep;

  // reserved bits are never stored, so they cannot read back as one
  assign wr_keep = i_wmask & `IFEPR_PCW_WMASK;
  assign o_rdata = rdata_q;

  // ****************************************************************
  // storage
  // ****************************************************************
  genvar w;
  generate
    for (w = 0; w < `IFEPR_NUM_PCW; w = w + 1) begin : g_word
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          word_q[w] <= `IFEPR_RST_WORD;
        end else if (i_wr && (i_widx == 3'(w))) begin
          word_q[w] <= (word_q[w] & ~wr_keep) | (i_wdata & wr_keep);
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q <= `IFEPR_RST_WORD;
    end else begin
      rdata_q <= word_q[i_ridx] & `IFEPR_PCW_WMASK;
    end
  end

  // ****************************************************************
  // per-source fields: slot k of word n is source 4n+k
  // ****************************************************************
  genvar s;
  generate
    for (s = 0; s < `IFEPR_NUM_SRC; s = s + 1) begin : g_src
      localparam int WI = s / `IFEPR_SRC_PER_PCW;
      localparam int SB = (s % `IFEPR_SRC_PER_PCW) * `IFEPR_SLOT_BITS;
      // binary value of the field is the level itself
      assign o_level[s*3 +: 3] = word_q[WI][SB+`IFEPR_LEVEL_LSB +: 3];
      assign o_sublevel[s*2 +: 2] = word_q[WI][SB+`IFEPR_SUBLEVEL_LSB +: 2];
    end
  endgenerate

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_reserved_read_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rdata_q & `IFEPR_PCW_RSVD) == 32'h00000000)
    else $error("reserved priority bits read as one");

  chk_top_slot_fields: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr && i_widx == 3'h0 && i_wmask[31:24] == 8'hFF) |=>
      (o_level[11:9] == $past(i_wdata[28:26])) && (o_sublevel[7:6] == $past(i_wdata[25:24])))
    else $error("slot three fields not at bits 28-24");

  chk_low_slot_fields: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr && i_widx == 3'h7 && i_wmask[7:0] == 8'hFF) |=>
      (o_level[86:84] == $past(i_wdata[4:2])) && (o_sublevel[57:56] == $past(i_wdata[1:0])))
    else $error("slot zero fields not at bits 4-0");

  chk_readback_word: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_wr && i_widx == i_ridx && i_wmask == 32'hFFFFFFFF) |=> ##1
      (rdata_q == ($past(i_wdata, 2) & `IFEPR_PCW_WMASK)) || $past(i_wr) || $past(i_ridx) != $past(i_ridx, 2))
    else $error("priority word read back wrong");

endmodule : ifepr_prio_bank

// ### core/ifepr_regs.sv
// interrupt pending flags, enables and priority words behind an Avalon-MM slave
`timescale 1ns/100ps
`include "ifepr_params.svh"

// Behaviour
// - pending flag sets on request, software read/write
// - enable bit one passes, zero blocks request
// - level field value equals priority level
// - level zero source reaches processor only in the cycle after the write that zeroes its level
// - sublevel field value equals subpriority
// - four sources per word, fixed field positions
// - unused high bits ignore writes, read zero

module ifepr_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // avalon-mm slave
  input wire logic [`IFEPR_ADDR_W-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // interrupt sources, one-cycle pulses from same-clock logic
  input wire logic [31:0] i_src_event,
  // toward the processor core
  output logic [31:0] o_cpu_req,
  output logic [95:0] o_src_level,
  output logic [63:0] o_src_sublevel,
  // block event interrupt
  output logic o_irq
);

  // ****************************************************************
  // state
  // ****************************************************************
  ifepr_pkg::ifepr_bus_state_type bus_q;
  ifepr_pkg::ifepr_bus_state_type bus_d;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] flags_q;
  logic [31:0] flags_d;
  logic [31:0] enable_q;
  logic [31:0] ev_status_q;
  logic [31:0] ev_status_d;
  logic [31:0] ev_mask_q;
  logic irq_q;
  logic [31:0] req_q;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire [`IFEPR_ADDR_W-1:0] word_addr = {i_address[`IFEPR_ADDR_W-1:2], 2'h0};
  wire sel_flags = (word_addr == `IFEPR_OFS_FLAGS);
  wire sel_enable = (word_addr == `IFEPR_OFS_ENABLE);
  wire sel_ev_status = (word_addr == `IFEPR_OFS_EV_STATUS);
  wire sel_ev_mask = (word_addr == `IFEPR_OFS_EV_MASK);
  wire sel_pcw = (word_addr >= `IFEPR_OFS_PCW_BASE) && (word_addr <= `IFEPR_OFS_PCW_LAST);
  wire [`IFEPR_ADDR_W-1:0] pcw_ofs = word_addr - `IFEPR_OFS_PCW_BASE;
  wire [2:0] pcw_idx = pcw_ofs[4:2];
  wire bus_req = i_read || i_write;
  // a write lands only at the edge where the master sees waitrequest low
  wire wr_fire = (bus_q == ifepr_pkg::IFEPR_BUS_ANSWER) && i_write;
  wire rd_fire = (bus_q == ifepr_pkg::IFEPR_BUS_ANSWER) && i_read;
  wire wr_flags = wr_fire && sel_flags;
  wire wr_enable = wr_fire && sel_enable;
  wire wr_ev_status = wr_fire && sel_ev_status;
  wire wr_ev_mask = wr_fire && sel_ev_mask;
  wire wr_pcw = wr_fire && sel_pcw;
  wire sel_any = sel_flags || sel_enable || sel_ev_status || sel_ev_mask || sel_pcw;
  wire [31:0] wmask = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}}, {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
  wire [31:0] wbits = i_writedata & wmask;

  // ****************************************************************
  // priority words
  // ****************************************************************
  logic [31:0] pcw_rdata;
  logic [95:0] level_w;
  logic [63:0] sublevel_w;

  ifepr_prio_bank u_bank (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr(wr_pcw),
    .i_widx(pcw_idx),
    .i_wdata(i_writedata),
    .i_wmask(wmask),
    .i_ridx(pcw_idx),
    .o_rdata(pcw_rdata),
    .o_level(level_w),
    .o_sublevel(sublevel_w)
  );

  // per-source level-zero detect
  logic [31:0] lvl_zero;
  genvar s;
  generate
    for (s = 0; s < `IFEPR_NUM_SRC; s = s + 1) begin : g_zero
      assign lvl_zero[s] = (level_w[s*3 +: 3] == 3'h0);
    end
  endgenerate

  // ****************************************************************
  // next values
  // ****************************************************************
  // a request in the same cycle as a software clear still sets the flag
  assign flags_d = (wr_flags ? ((flags_q & ~wmask) | wbits) : flags_q) | i_src_event;
  wire ev_new = |i_src_event;
  wire ev_blocked = |(i_src_event & lvl_zero);
  wire [31:0] ev_set = {30'h00000000, ev_blocked, ev_new};
  wire [31:0] ev_clr = wr_ev_status ? (wbits & `IFEPR_EV_BITS) : 32'h00000000;
  assign ev_status_d = (ev_status_q & ~ev_clr) | ev_set;
  // disabled or level-zero sources are cut off here, pending flag kept
  wire [31:0] req_d = flags_q & enable_q & ~lvl_zero;

  wire [31:0] rd_mux =
    sel_flags ? flags_q :
    sel_enable ? enable_q :
    sel_ev_status ? ev_status_q :
    sel_ev_mask ? ev_mask_q :
    sel_pcw ? pcw_rdata : 32'h00000000;

  always_comb begin
    case (bus_q)
      ifepr_pkg::IFEPR_BUS_IDLE: bus_d = bus_req ? ifepr_pkg::IFEPR_BUS_FETCH : ifepr_pkg::IFEPR_BUS_IDLE;
      ifepr_pkg::IFEPR_BUS_FETCH: bus_d = ifepr_pkg::IFEPR_BUS_ANSWER;
      ifepr_pkg::IFEPR_BUS_ANSWER: bus_d = ifepr_pkg::IFEPR_BUS_IDLE;
      default: bus_d = ifepr_pkg::IFEPR_BUS_IDLE;
    endcase
  end

  // ****************************************************************
  // bus slave: two wait cycles so the bank read can settle
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bus_q <= ifepr_pkg::IFEPR_BUS_IDLE;
      wait_q <= 1'h1;
      rdata_q <= `IFEPR_RST_WORD;
    end else begin
      bus_q <= bus_d;
      wait_q <= (bus_d != ifepr_pkg::IFEPR_BUS_ANSWER);
      if (bus_q == ifepr_pkg::IFEPR_BUS_FETCH) begin
        rdata_q <= i_read ? rd_mux : 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flags_q <= `IFEPR_RST_WORD;
      enable_q <= `IFEPR_RST_WORD;
      ev_status_q <= `IFEPR_RST_WORD;
      ev_mask_q <= `IFEPR_RST_WORD;
    end else begin
      flags_q <= flags_d;
      ev_status_q <= ev_status_d;
      if (wr_enable) begin
        enable_q <= (enable_q & ~wmask) | wbits;
      end
      if (wr_ev_mask) begin
        ev_mask_q <= (ev_mask_q & ~wmask) | (wbits & `IFEPR_EV_BITS);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      req_q <= `IFEPR_RST_WORD;
      irq_q <= 1'h0;
    end else begin
      req_q <= req_d;
      irq_q <= |(ev_status_d & ev_mask_q);
    end
  end

  assign o_readdata = rdata_q;
  assign o_waitrequest = wait_q;
  assign o_cpu_req = req_q;
  assign o_src_level = level_w;
  assign o_src_sublevel = sublevel_w;
  assign o_irq = irq_q;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_flag_event_sets: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (|i_src_event) |=> ((flags_q & $past(i_src_event)) == $past(i_src_event)))
    else $error("request did not set its pending flag");

  chk_flag_sw_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_fire && sel_flags && i_byteenable == 4'hF && i_src_event == 32'h00000000)
      |=> flags_q == $past(i_writedata))
    else $error("flag word write not stored");

  chk_enable_gates_req: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 (o_cpu_req == ($past(flags_q) & $past(enable_q) & ~$past(lvl_zero))))
    else $error("processor request not flag and enable");

  chk_level_zero_silent: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (lvl_zero[0] && lvl_zero[31]) [*2] |-> (o_cpu_req[0] == 1'h0) && (o_cpu_req[31] == 1'h0))
    else $error("level zero source reached processor");

  chk_reset_clears: assert property (@(posedge i_clk)
    !i_rst_n |=> (flags_q == 32'h00000000) && (enable_q == 32'h00000000) && (o_src_level == 96'h0))
    else $error("reset left state set");

  chk_answer_one_cycle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bus_req && bus_q == ifepr_pkg::IFEPR_BUS_IDLE) |=> o_waitrequest ##1 !o_waitrequest ##1 o_waitrequest)
    else $error("waitrequest low not exactly one cycle");

  chk_status_sticky: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ev_new |=> ev_status_q[`IFEPR_EV_NEW_BIT] ##1 (ev_status_q[`IFEPR_EV_NEW_BIT] || $past(wr_fire)))
    else $error("event status bit not sticky");

  // ****************************************************************
  // bus, flag, enable, status, request and priority field checks
  // ****************************************************************
  chk_enable_sw_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_enable && i_byteenable == 4'hF) |=> enable_q == $past(i_writedata))
    else $error("enable word write not stored");

  chk_enable_zero_blocks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (enable_q != 32'hFFFFFFFF) |=> ((o_cpu_req & ~$past(enable_q)) == 32'h00000000))
    else $error("disabled source reached processor");

  chk_flag_holds_idle: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!wr_flags && i_src_event == 32'h00000000) |=> flags_q == $past(flags_q))
    else $error("pending flag moved without request or write");

  chk_flag_no_spurious: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !wr_flags |=> ((flags_q & ~$past(flags_q) & ~$past(i_src_event)) == 32'h00000000))
    else $error("pending flag set without a request");

  chk_zero_level_masked: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (|lvl_zero) |=> ((o_cpu_req & $past(lvl_zero)) == 32'h00000000))
    else $error("level zero request presented");

  chk_req_needs_flag: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (flags_q != 32'hFFFFFFFF) |=> ((o_cpu_req & ~$past(flags_q)) == 32'h00000000))
    else $error("request presented without pending flag");

  chk_reset_outputs_idle: assert property (@(posedge i_clk)
    !i_rst_n |=> o_waitrequest && !o_irq && (o_readdata == 32'h00000000) && (o_cpu_req == 32'h00000000)
      && (o_src_sublevel == 64'h0000000000000000))
    else $error("outputs not idle after reset");

  chk_unmapped_read_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rd_fire && !sel_any) |-> o_readdata == 32'h00000000)
    else $error("unmapped read returned data");

  // a flag read is compared only when the flags held still across the fetch edge
  chk_flags_read_back: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rd_fire && sel_flags && $stable(flags_q)) |-> o_readdata == flags_q)
    else $error("flag word read back wrong");

  chk_enable_read_back: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rd_fire && sel_enable) |-> o_readdata == enable_q)
    else $error("enable word read back wrong");

  chk_mask_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ev_mask_q & ~`IFEPR_EV_BITS) == 32'h00000000)
    else $error("unused event mask bits set");

  chk_status_reserved_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (ev_status_q & ~`IFEPR_EV_BITS) == 32'h00000000)
    else $error("unused event status bits set");

  // the interrupt trails a mask write by one edge
  chk_irq_follows_status: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !$past(wr_ev_mask) |-> (o_irq == (|(ev_status_q & ev_mask_q))))
    else $error("interrupt does not follow masked status");

  chk_blocked_sets_status: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (|(i_src_event & lvl_zero)) |=> ev_status_q[`IFEPR_EV_BLOCKED_BIT])
    else $error("level zero request not flagged in status");

  chk_status_write_clears: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_ev_status && i_writedata[`IFEPR_EV_NEW_BIT] && i_byteenable[0] && !ev_new)
      |=> !ev_status_q[`IFEPR_EV_NEW_BIT])
    else $error("status write of one did not clear");

  chk_readdata_stands: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (bus_q == ifepr_pkg::IFEPR_BUS_ANSWER) |=> $stable(o_readdata))
    else $error("read data changed after the answer");

  chk_wait_low_answer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_waitrequest |-> (bus_q == ifepr_pkg::IFEPR_BUS_ANSWER))
    else $error("waitrequest low outside the answer cycle");

  chk_mask_write_lands: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wr_ev_mask && i_byteenable[0]) |=> (ev_mask_q[1:0] == $past(i_writedata[1:0])))
    else $error("event mask write not stored");

  // level and sublevel outputs move only on a priority word write
  chk_fields_hold_still: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !wr_pcw |=> $stable(o_src_level) && $stable(o_src_sublevel))
    else $error("priority fields moved without a write");

endmodule : ifepr_regs

// ### inc/ifepr_params.svh
// offsets, field positions, reset values and masks of the interrupt flag/enable/priority registers
`ifndef IFEPR_PARAMS_SVH
`define IFEPR_PARAMS_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define IFEPR_NUM_SRC 32
`define IFEPR_NUM_PCW 8
`define IFEPR_SRC_PER_PCW 4
`define IFEPR_SLOT_BITS 8
`define IFEPR_LEVEL_W 3
`define IFEPR_SUBLEVEL_W 2
`define IFEPR_LEVEL_LSB 2
`define IFEPR_SUBLEVEL_LSB 0
`define IFEPR_ADDR_W 8

// ****************************************************************
// byte offsets on the register bus
// ****************************************************************
`define IFEPR_OFS_FLAGS 8'h00
`define IFEPR_OFS_ENABLE 8'h04
`define IFEPR_OFS_EV_STATUS 8'h08
`define IFEPR_OFS_EV_MASK 8'h0C
`define IFEPR_OFS_PCW_BASE 8'h10
`define IFEPR_OFS_PCW_LAST 8'h2C

// ****************************************************************
// masks and reset values
// ****************************************************************
`define IFEPR_PCW_WMASK 32'h1F1F1F1F
`define IFEPR_PCW_RSVD 32'hE0E0E0E0
`define IFEPR_EV_BITS 32'h00000003
`define IFEPR_EV_NEW_BIT 0
`define IFEPR_EV_BLOCKED_BIT 1
`define IFEPR_RST_WORD 32'h00000000

`endif

// ### inc/ifepr_pkg.sv
// types shared by the interrupt flag/enable/priority register block
package ifepr_pkg;

  typedef enum logic [1:0] {
    IFEPR_BUS_IDLE = 2'b00,
    IFEPR_BUS_FETCH = 2'b01,
    IFEPR_BUS_ANSWER = 2'b10
  } ifepr_bus_state_type;

endpackage : ifepr_pkg

// ### sim/ifepr_core_model.sv
// processor-side consumer of the prioritized requests
`timescale 1ns/100ps

module ifepr_core_model (
  // requests and levels from the register block
  input wire logic [31:0] i_req,
  input wire logic [95:0] i_level,
  // highest presented level, and a flag for a level-zero request
  output logic [2:0] o_best_level,
  output logic o_zero_seen
);
  // the core takes whatever is presented; a level-zero request is a device fault
  always_comb begin
    o_best_level = 3'h0;
    o_zero_seen = 1'h0;
    for (int s = 0; s < 32; s++) begin
      if (i_req[s] && i_level[3*s +: 3] > o_best_level) o_best_level = i_level[3*s +: 3];
      if (i_req[s] && i_level[3*s +: 3] == 3'h0) o_zero_seen = 1'h1;
    end
  end
endmodule : ifepr_core_model

// ### sim/irq_flag_enable_priority_regs_test.sv
// self-checking bench for the interrupt flag/enable/priority register block
`timescale 1ns/100ps
`include "ifepr_params.svh"

module irq_flag_enable_priority_regs_test;
  logic i_clk, i_rst_n, i_read, i_write, o_waitrequest, o_irq, core_zero;
  logic [7:0] i_address;
  logic [31:0] i_writedata, i_src_event, o_readdata, o_cpu_req, rd, d;
  logic [31:0] m_flags, m_en, m_stat, m_mask;
  logic [31:0] m_pcw [8];
  logic [3:0] i_byteenable;
  logic [95:0] o_src_level;
  logic [63:0] o_src_sublevel;
  logic [2:0] core_best;
  int n_errors, checked, seed_val;

  ifepr_regs dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read),
    .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .i_src_event(i_src_event), .o_cpu_req(o_cpu_req),
    .o_src_level(o_src_level), .o_src_sublevel(o_src_sublevel), .o_irq(o_irq));
  ifepr_core_model core (.i_req(o_cpu_req), .i_level(o_src_level), .o_best_level(core_best),
    .o_zero_seen(core_zero));

  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end

  initial begin
    #100000;
    n_errors++;
    $display("BAD watchdog expected end seen hang");
    final_report();
  end

  // ****************************************************************
  // checking and bus tasks
  // ****************************************************************
  task final_report;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // entered just after a rising edge; ends one idle edge after the answer
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
    int n;
    n = 0;
    i_address <= a;
    i_writedata <= wd;
    i_byteenable <= be;
    i_write <= wr;
    i_read <= !wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_waitrequest !== 1'h0 && n < 40);
    rd = o_readdata;
    i_write <= 1'h0;
    i_read <= 1'h0;
    @(posedge i_clk);
    if (n >= 40) begin
      n_errors++;
      $display("BAD waitrequest expected low seen high");
      final_report();
    end
  endtask : bus

  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'h0, a, 32'h0, 4'hF);
    chk("readdata", exp, rd);
  endtask : rd_chk

  function automatic logic [2:0] lvl(int s);
    return m_pcw[s/4][8*(s%4)+2 +: 3];
  endfunction : lvl

  task chk_out;
    logic [31:0] e;
    logic [2:0] b;
    b = 3'h0;
    for (int s = 0; s < 32; s++) e[s] = m_flags[s] & m_en[s] & (lvl(s) != 3'h0);
    @(negedge i_clk);
    chk("cpu_req", e, o_cpu_req);
    for (int s = 0; s < 32; s++) begin
      if (e[s] && lvl(s) > b) b = lvl(s);
      chk("level", {29'h0, lvl(s)}, {29'h0, o_src_level[3*s +: 3]});
      chk("sublevel", {30'h0, m_pcw[s/4][8*(s%4) +: 2]}, {30'h0, o_src_sublevel[2*s +: 2]});
    end
    chk("core level", {29'h0, b}, {29'h0, core_best});
    chk("core zero", 32'h0, {31'h0, core_zero});
    chk("irq", {31'h0, |(m_stat & m_mask)}, {31'h0, o_irq});
    @(posedge i_clk);
  endtask : chk_out

  task model_clear;
    m_flags = 32'h0;
    m_en = 32'h0;
    m_stat = 32'h0;
    m_mask = 32'h0;
    for (int w = 0; w < 8; w++) m_pcw[w] = 32'h0;
  endtask : model_clear

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    i_rst_n = 1'h0;
    i_read = 1'h0;
    i_write = 1'h0;
    i_address = 8'h00;
    i_writedata = 32'h0;
    i_byteenable = 4'hF;
    i_src_event = 32'h0;
    model_clear();
    seed_val = $urandom(32'h8936);
    repeat (10) @(posedge i_clk);
    for (int r = 0; r < 2; r++) begin
      // second pass repeats the reset checks after a reset in mid-run
      i_rst_n <= 1'h1;
      @(posedge i_clk);
      for (int a = 0; a <= 32'h30; a += 4) rd_chk(8'(a), 32'h0);
      chk_out();
      // each word gets one level code in slot 0, random elsewhere
      for (int w = 0; w < 8; w++) begin
        d = $urandom;
        d[4:2] = w[2:0];
        bus(1'h1, 8'(8'h10 + 4*w), d, 4'hF);
        m_pcw[w] = d & `IFEPR_PCW_WMASK;
      end
      d = $urandom;
      bus(1'h1, 8'h14, d, 4'h2);
      m_pcw[1][15:8] = d[15:8] & 8'h1F;
      for (int w = 0; w < 8; w++) rd_chk(8'(8'h10 + 4*w), m_pcw[w]);
      bus(1'h1, 8'h0C, 32'h3, 4'hF);
      m_mask = 32'h3;
      for (int k = 0; k < 4; k++) begin
        d = $urandom;
        bus(1'h1, 8'h04, d, 4'hF);
        m_en = d;
        d = $urandom;
        i_src_event <= d;
        @(posedge i_clk);
        i_src_event <= 32'h0;
        m_flags |= d;
        m_stat[0] |= (d != 32'h0);
        for (int s = 0; s < 32; s++) if (d[s] && lvl(s) == 3'h0) m_stat[1] = 1'h1;
        @(posedge i_clk);
        chk_out();
        rd_chk(8'h00, m_flags);
        rd_chk(8'h04, m_en);
        rd_chk(8'h08, m_stat);
        d = $urandom;
        bus(1'h1, 8'h00, d, 4'hF);
        m_flags = d;
        chk_out();
        bus(1'h1, 8'h08, 32'hFFFFFFFF, 4'hF);
        m_stat = 32'h0;
        chk_out();
        m_mask = {30'h0, k[1:0]};
        bus(1'h1, 8'h0C, m_mask, 4'hF);
      end
      i_rst_n <= 1'h0;
      repeat (2) @(posedge i_clk);
      model_clear();
    end
    final_report();
  end
endmodule : irq_flag_enable_priority_regs_test
